// ==== shared/irq_ctrl_pkg.sv ====
package irq_ctrl_pkg;
    localparam int NSRC = 11;
    localparam int STACK_DEPTH = 12;
    localparam int CTRL_W = 14;
    // source indices, lower index wins
    localparam logic [3:0] SRC_PWD = 4'h0;
    localparam logic [3:0] SRC_IRQ_A = 4'h1;
    localparam logic [3:0] SRC_LVL_B = 4'h2;
    localparam logic [3:0] SRC_LVL_A = 4'h3;
    localparam logic [3:0] SRC_SP0_TX = 4'h4;
    localparam logic [3:0] SRC_SP0_RX = 4'h5;
    localparam logic [3:0] SRC_EDGE = 4'h6;
    localparam logic [3:0] SRC_BYTE_DMA_PORT = 4'h7;
    localparam logic [3:0] SRC_SP1_TX = 4'h8;
    localparam logic [3:0] SRC_SP1_RX = 4'h9;
    localparam logic [3:0] SRC_TIMER = 4'hA;
    localparam logic [3:0] IDX_RESET = 4'hE;
    localparam logic [3:0] IDX_NONE = 4'hF;
    // register byte offsets
    localparam logic [7:0] ADDR_MASK = 8'h00;
    localparam logic [7:0] ADDR_CTRL = 8'h04;
    localparam logic [7:0] ADDR_FORCE = 8'h08;
    localparam logic [7:0] ADDR_STATUS = 8'h0C;
    localparam logic [7:0] ADDR_FLAGS = 8'h10;
    localparam logic [7:0] ADDR_GIE = 8'h14;
    // field positions
    localparam int CTRL_EDGE_A = 0;
    localparam int CTRL_EDGE_RX = 1;
    localparam int CTRL_EDGE_TX = 2;
    localparam int CTRL_NEST = 4;
    localparam int CTRL_ALT = 5;
    localparam int CTRL_PUCB = 6;
    localparam int CTRL_ABUF_LO = 8;
    localparam int CTRL_FO = 12;
    localparam int CTRL_SCLK = 13;
    localparam int FORCE_CLR_LO = 16;
    localparam int STAT_ACT_LO = 16;
    localparam int STAT_DEPTH_LO = 24;
    localparam int STAT_GIE = 31;
    localparam int GIE_ON = 0;
    localparam int GIE_OFF = 1;
    // reset values
    localparam logic [NSRC-2:0] MASK_RST = 10'h000;
    localparam logic [CTRL_W-1:0] CTRL_RST = 14'h0000;
    localparam logic GIE_RST = 1'b1;
    localparam logic [3:0] PIN_IDLE = 4'hF;
    localparam logic [13:0] VEC_RESET = 14'h0000;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic {WR_IDLE = 1'b0, WR_RESP = 1'b1} wr_state_t;

    function automatic logic [13:0] vec_of(input logic [3:0] idx);
        case (idx)
            SRC_PWD: vec_of = 14'h002C;
            SRC_IRQ_A: vec_of = 14'h0004;
            SRC_LVL_B: vec_of = 14'h0008;
            SRC_LVL_A: vec_of = 14'h000C;
            SRC_SP0_TX: vec_of = 14'h0010;
            SRC_SP0_RX: vec_of = 14'h0014;
            SRC_EDGE: vec_of = 14'h0018;
            SRC_BYTE_DMA_PORT: vec_of = 14'h001C;
            SRC_SP1_TX: vec_of = 14'h0020;
            SRC_SP1_RX: vec_of = 14'h0024;
            SRC_TIMER: vec_of = 14'h0028;
            default: vec_of = VEC_RESET;
        endcase
    endfunction
endpackage

// ==== shared/prio_if.sv ====
`timescale 1ns/100ps
`default_nettype none
interface prio_if;
    import irq_ctrl_pkg::*;
    logic clk;
    logic rstn;
    logic [NSRC-1:0] pend;
    logic [NSRC-2:0] mask;
    logic gie;
    logic blocked;
    logic nest_en;
    logic [3:0] act_idx;
    logic sel_valid;
    logic [3:0] sel_idx;
    modport ctl (output clk, rstn, pend, mask, gie, blocked, nest_en,
        act_idx, input sel_valid, sel_idx);
    modport prio (input clk, rstn, pend, mask, gie, blocked, nest_en,
        act_idx, output sel_valid, sel_idx);
endinterface
`default_nettype wire

// ==== hw/irq_prio.sv ====
`timescale 1ns/100ps
`default_nettype none
module irq_prio (
    prio_if.prio p
);
    import irq_ctrl_pkg::*;
    logic [NSRC-1:0] elig;
    logic [NSRC-1:0] mask_ext;

    // power-down has no mask bit
    assign mask_ext = {p.mask, 1'b1};

    // requests that may be taken this cycle
    always_comb begin
        for (int i = 0; i < NSRC; i++) begin
            elig[i] = p.pend[i] && mask_ext[i]
                && p.gie && !p.blocked
                && (p.act_idx == IDX_NONE
                    || (p.nest_en && 4'(i) < p.act_idx));
        end
    end

    // lowest index wins, fixed order
    always_comb begin
        p.sel_valid = 1'b0;
        p.sel_idx = IDX_NONE;
        for (int i = NSRC - 1; i >= 0; i--) begin
            if (elig[i]) begin
                p.sel_valid = 1'b1;
                p.sel_idx = 4'(i);
            end
        end
    end

    AST_MASKED_NOT_SEL: assert property (@(posedge p.clk)
        disable iff (!p.rstn)
        p.sel_valid |-> mask_ext[p.sel_idx] && p.pend[p.sel_idx])
        else $error("masked request selected");
    AST_PRIO_HIGHEST: assert property (@(posedge p.clk)
        disable iff (!p.rstn)
        p.sel_valid |-> (elig & ((11'h001 << p.sel_idx) - 11'h001))
            == 11'h000)
        else $error("higher eligible request skipped");
endmodule
`default_nettype wire

// ==== hw/irq_ctrl_top.sv ====
`timescale 1ns/100ps
`default_nettype none
module irq_ctrl_top (
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic ext_irq_prog_a_n,
    input wire logic level_irq_b_n,
    input wire logic level_irq_a_n,
    input wire logic edge_irq_n,
    input wire logic sport_alt_irq_rx_n,
    input wire logic sport_alt_irq_tx_n,
    input wire logic alt_flag_in,
    input wire logic pwd_req,
    input wire logic pwrup_wake,
    input wire logic [3:0] sp_word_done,
    input wire logic [3:0] sp_buf_done,
    input wire logic byte_dma_port_done,
    input wire logic timer_tick,
    input wire logic vec_ack,
    input wire logic vec_rti,
    input wire logic stk_push,
    input wire logic stk_pop,
    output logic vec_valid,
    output logic [13:0] vec_addr,
    output logic alt_flag_out,
    output logic serial_port_one_alt_mode,
    output logic serial_port_one_sclk_int_en
);
    import irq_ctrl_pkg::*;

    logic awready_r, wready_r, bvalid_r, arready_r, rvalid_r;
    logic [1:0] bresp_r, rresp_r;
    logic [31:0] rdata_r;
    logic [7:0] awaddr_r;
    logic [31:0] wdata_r;
    logic [3:0] wstrb_r;
    logic aw_got_r, w_got_r;
    wr_state_t wr_st_r;
    logic [NSRC-2:0] mask_r;
    logic [CTRL_W-1:0] ctrl_r;
    logic gie_r, block_r, rst_req_r;
    logic [NSRC-1:0] latch_r;
    logic vec_valid_r;
    logic [3:0] vec_idx_r;
    logic [13:0] vec_addr_r;
    logic [3:0] act_r;
    logic [3:0] stk_r [STACK_DEPTH];
    logic [3:0] depth_r;
    logic [3:0] pin_prev_r;
    logic [3:0] pin_now, pin_fall, sec_ev;
    logic [NSRC-1:0] ev, lvl, pend, force_set, force_clr, ack_src;
    logic [31:0] wmask, wval, rd_val;
    logic wr_do, wr_hit, wr_mask, wr_ctrl, wr_force, wr_gie, rd_hit;
    logic ack_take, ack_rst, push_req, pop_req;
    logic alt_mode;

    assign s_axi_awready = awready_r;
    assign s_axi_wready = wready_r;
    assign s_axi_bvalid = bvalid_r;
    assign s_axi_bresp = bresp_r;
    assign s_axi_arready = arready_r;
    assign s_axi_rvalid = rvalid_r;
    assign s_axi_rdata = rdata_r;
    assign s_axi_rresp = rresp_r;
    assign vec_valid = vec_valid_r;
    assign vec_addr = vec_addr_r;
    // port one clock enable does not depend on the alternate mode
    assign serial_port_one_sclk_int_en = ctrl_r[CTRL_SCLK];
    assign serial_port_one_alt_mode = ctrl_r[CTRL_ALT];
    assign alt_flag_out = ctrl_r[CTRL_FO];
    assign alt_mode = ctrl_r[CTRL_ALT];

    // write decode, byte lanes merged into one mask
    assign wr_do = (wr_st_r == WR_IDLE) && aw_got_r && w_got_r;
    assign wmask = {{8{wstrb_r[3]}}, {8{wstrb_r[2]}},
        {8{wstrb_r[1]}}, {8{wstrb_r[0]}}};
    assign wval = wdata_r & wmask;
    assign wr_mask = wr_do && awaddr_r == ADDR_MASK;
    assign wr_ctrl = wr_do && awaddr_r == ADDR_CTRL;
    assign wr_force = wr_do && awaddr_r == ADDR_FORCE;
    assign wr_gie = wr_do && awaddr_r == ADDR_GIE;
    assign wr_hit = wr_mask || wr_ctrl || wr_force || wr_gie
        || awaddr_r == ADDR_STATUS || awaddr_r == ADDR_FLAGS;
    // force register only acts on the write, reads back zero
    assign force_set = wr_force ? wval[NSRC-1:0] : '0;
    assign force_clr = wr_force ? wval[FORCE_CLR_LO +: NSRC] : '0;

    // write address channel, one write in flight
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            awready_r <= 1'b0;
            aw_got_r <= 1'b0;
            awaddr_r <= 8'h00;
        end else if (s_axi_awvalid && awready_r) begin
            awready_r <= 1'b0;
            aw_got_r <= 1'b1;
            awaddr_r <= {s_axi_awaddr[7:2], 2'b00};
        end else if (wr_st_r == WR_RESP && s_axi_bready) begin
            aw_got_r <= 1'b0;
        end else if (wr_st_r == WR_IDLE && !aw_got_r) begin
            awready_r <= 1'b1;
        end
    end

    // write data channel, taken in either order with the address
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            wready_r <= 1'b0;
            w_got_r <= 1'b0;
            wdata_r <= 32'h0000_0000;
            wstrb_r <= 4'h0;
        end else if (s_axi_wvalid && wready_r) begin
            wready_r <= 1'b0;
            w_got_r <= 1'b1;
            wdata_r <= s_axi_wdata;
            wstrb_r <= s_axi_wstrb;
        end else if (wr_st_r == WR_RESP && s_axi_bready) begin
            w_got_r <= 1'b0;
        end else if (wr_st_r == WR_IDLE && !w_got_r) begin
            wready_r <= 1'b1;
        end
    end

    // write response follows both halves
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            wr_st_r <= WR_IDLE;
            bvalid_r <= 1'b0;
            bresp_r <= RESP_OKAY;
        end else begin
            case (wr_st_r)
                WR_IDLE: begin
                    if (wr_do) begin
                        bvalid_r <= 1'b1;
                        bresp_r <= wr_hit ? RESP_OKAY : RESP_SLVERR;
                        wr_st_r <= WR_RESP;
                    end
                end
                WR_RESP: begin
                    if (s_axi_bready) begin
                        bvalid_r <= 1'b0;
                        wr_st_r <= WR_IDLE;
                    end
                end
                default: wr_st_r <= WR_IDLE;
            endcase
        end
    end

    // read mux; flag pins read back while still raising interrupts
    always_comb begin
        rd_val = 32'h0000_0000;
        rd_hit = 1'b1;
        case ({s_axi_araddr[7:2], 2'b00})
            ADDR_MASK: rd_val[NSRC-2:0] = mask_r;
            ADDR_CTRL: rd_val[CTRL_W-1:0] = ctrl_r;
            ADDR_FORCE: rd_val = 32'h0000_0000;
            ADDR_STATUS: begin
                rd_val[NSRC-1:0] = pend;
                rd_val[STAT_ACT_LO +: 4] = act_r;
                rd_val[STAT_DEPTH_LO +: 4] = depth_r;
                rd_val[STAT_GIE] = gie_r;
            end
            ADDR_FLAGS: rd_val[4:0] = {alt_flag_in, ext_irq_prog_a_n,
                level_irq_b_n, level_irq_a_n, edge_irq_n};
            ADDR_GIE: rd_val[GIE_ON] = gie_r;
            default: rd_hit = 1'b0;
        endcase
    end

    // read channel, answer one cycle after the address is taken
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            arready_r <= 1'b0;
            rvalid_r <= 1'b0;
            rdata_r <= 32'h0000_0000;
            rresp_r <= RESP_OKAY;
        end else if (s_axi_arvalid && arready_r) begin
            arready_r <= 1'b0;
            rvalid_r <= 1'b1;
            rdata_r <= rd_val;
            rresp_r <= rd_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (rvalid_r && s_axi_rready) begin
            rvalid_r <= 1'b0;
        end else if (!rvalid_r) begin
            arready_r <= 1'b1;
        end
    end

    // software registers
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            mask_r <= MASK_RST;
            ctrl_r <= CTRL_RST;
        end else begin
            if (wr_mask) begin
                mask_r <= (mask_r & ~wmask[NSRC-2:0]) | wval[NSRC-2:0];
            end
            if (wr_ctrl) begin
                ctrl_r <= (ctrl_r & ~wmask[CTRL_W-1:0]) | wval[CTRL_W-1:0];
            end
        end
    end

    // global enable, stands for the enable and disable instructions
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            gie_r <= GIE_RST;
        end else if (wr_gie && wval[GIE_ON]) begin
            gie_r <= 1'b1;
        end else if (wr_gie && wval[GIE_OFF]) begin
            gie_r <= 1'b0;
        end
    end

    // one dead cycle after a mask write; event latching carries on
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            block_r <= 1'b0;
        end else begin
            block_r <= wr_mask;
        end
    end

    // pins idle high, so the first sample cannot fake an edge
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            pin_prev_r <= PIN_IDLE;
        end else begin
            pin_prev_r <= pin_now;
        end
    end
    assign pin_now = {sport_alt_irq_tx_n, sport_alt_irq_rx_n,
        edge_irq_n, ext_irq_prog_a_n};
    assign pin_fall = pin_prev_r & ~pin_now;

    // serial sections: per word, or per buffer when autobuffering
    for (genvar k = 0; k < 4; k++) begin : g_sec
        assign sec_ev[k] = ctrl_r[CTRL_ABUF_LO + k] ? sp_buf_done[k]
            : sp_word_done[k];
    end

    // edge events per source
    always_comb begin
        ev = '0;
        ev[SRC_PWD] = pwd_req;
        ev[SRC_IRQ_A] = ctrl_r[CTRL_EDGE_A] && pin_fall[0];
        ev[SRC_SP0_TX] = sec_ev[0];
        ev[SRC_SP0_RX] = sec_ev[1];
        ev[SRC_EDGE] = pin_fall[1];
        ev[SRC_BYTE_DMA_PORT] = byte_dma_port_done;
        ev[SRC_SP1_TX] = alt_mode ? ctrl_r[CTRL_EDGE_TX] && pin_fall[3]
            : sec_ev[2];
        ev[SRC_SP1_RX] = alt_mode ? ctrl_r[CTRL_EDGE_RX] && pin_fall[2]
            : sec_ev[3];
        ev[SRC_TIMER] = timer_tick;
    end

    // level requests pass straight through, never latched
    always_comb begin
        lvl = '0;
        lvl[SRC_IRQ_A] = !ctrl_r[CTRL_EDGE_A] && !ext_irq_prog_a_n;
        lvl[SRC_LVL_B] = !level_irq_b_n;
        lvl[SRC_LVL_A] = !level_irq_a_n;
        lvl[SRC_SP1_TX] = alt_mode && !ctrl_r[CTRL_EDGE_TX]
            && !sport_alt_irq_tx_n;
        lvl[SRC_SP1_RX] = alt_mode && !ctrl_r[CTRL_EDGE_RX]
            && !sport_alt_irq_rx_n;
    end

    assign ack_take = vec_ack && vec_valid_r;
    assign ack_rst = ack_take && vec_idx_r == IDX_RESET;

    // latched requests; a new event beats a clear in the same cycle
    for (genvar g = 0; g < NSRC; g++) begin : g_latch
        assign ack_src[g] = ack_take && vec_idx_r == 4'(g);
        always_ff @(posedge clk_sys or negedge rstn) begin
            if (!rstn) begin
                latch_r[g] <= 1'b0;
            end else if (ev[g] || force_set[g]) begin
                latch_r[g] <= 1'b1;
            end else if (force_clr[g] || ack_src[g]) begin
                latch_r[g] <= 1'b0;
            end
        end
    end
    assign pend = latch_r | lvl;

    prio_if pif();
    assign pif.clk = clk_sys;
    assign pif.rstn = rstn;
    assign pif.pend = pend;
    assign pif.mask = mask_r;
    assign pif.gie = gie_r;
    assign pif.blocked = block_r;
    assign pif.nest_en = ctrl_r[CTRL_NEST];
    assign pif.act_idx = act_r;

    irq_prio u_prio (
        .p(pif.prio)
    );

    // reset request outranks all and ignores enables
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            rst_req_r <= 1'b1;
        end else if (pwrup_wake && ctrl_r[CTRL_PUCB]) begin
            rst_req_r <= 1'b1;
        end else if (ack_rst) begin
            rst_req_r <= 1'b0;
        end
    end

    // vector offer; dropped on the ack edge so a stale one never repeats
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            vec_valid_r <= 1'b0;
            vec_idx_r <= IDX_RESET;
            vec_addr_r <= VEC_RESET;
        end else if (ack_take) begin
            vec_valid_r <= 1'b0;
        end else if (rst_req_r) begin
            vec_valid_r <= 1'b1;
            vec_idx_r <= IDX_RESET;
            vec_addr_r <= VEC_RESET;
        end else begin
            vec_valid_r <= pif.sel_valid;
            vec_idx_r <= pif.sel_idx;
            vec_addr_r <= vec_of(pif.sel_idx);
        end
    end

    // status stack, shared with loop and call nesting
    assign push_req = (ack_take && !ack_rst) || stk_push;
    assign pop_req = vec_rti || stk_pop;

    // overflow drops the newest context, depth holds at 12; software watches depth
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            depth_r <= 4'h0;
            act_r <= IDX_NONE;
        end else if (ack_rst) begin
            depth_r <= 4'h0;
            act_r <= IDX_NONE;
        end else if (push_req) begin
            if (depth_r < STACK_DEPTH) begin
                depth_r <= depth_r + 4'h1;
            end
            if (ack_take) begin
                act_r <= vec_idx_r;
            end
        end else if (pop_req && depth_r != 4'h0) begin
            depth_r <= depth_r - 4'h1;
            if (vec_rti) begin
                act_r <= stk_r[depth_r - 4'h1];
            end
        end
    end

    // stack storage, no reset needed
    always_ff @(posedge clk_sys) begin
        if (push_req && !ack_rst && depth_r < STACK_DEPTH) begin
            stk_r[depth_r] <= act_r;
        end
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rstn);

    sequence s_dead_cycle;
        block_r ##1 !block_r;
    endsequence
    AST_RESET_VEC: assert property (rst_req_r && !ack_take
        |=> vec_valid_r && vec_addr_r == VEC_RESET)
        else $error("reset vector not offered");
    AST_MASK_WR_BLOCK: assert property (wr_mask && !wr_st_r
        |=> s_dead_cycle)
        else $error("mask write did not block one cycle");
    AST_BLOCK_NO_VEC: assert property (block_r && !rst_req_r
        |=> !vec_valid_r)
        else $error("vector during blocked cycle");
    AST_GIE_OFF: assert property (!gie_r && !rst_req_r
        |=> !vec_valid_r)
        else $error("vector while globally disabled");
    AST_SEQUENTIAL: assert property (act_r != IDX_NONE
        && !ctrl_r[CTRL_NEST] && !rst_req_r |=> !vec_valid_r)
        else $error("preempted with nesting off");
    AST_PREEMPT: assert property (vec_valid_r && act_r != IDX_NONE
        && vec_idx_r != IDX_RESET |-> vec_idx_r < act_r)
        else $error("preempt by equal or lower priority");
    AST_EDGE_ACK_CLR: assert property (ack_src[SRC_EDGE]
        && !ev[SRC_EDGE] && !force_set[SRC_EDGE]
        |=> !latch_r[SRC_EDGE])
        else $error("edge request not cleared on vector");
    AST_EDGE_FORCE: assert property (force_set[SRC_EDGE]
        |=> latch_r[SRC_EDGE])
        else $error("edge request not forced");
    AST_PWD_VEC: assert property (vec_valid_r && vec_idx_r == SRC_PWD
        |-> vec_addr_r == 14'h002C)
        else $error("power-down vector wrong");
endmodule
`default_nettype wire

// ==== test/irq_src.sv ====
`timescale 1ns/100ps
`default_nettype none
// far-end request lines, all active low
module irq_src (
    input wire logic clk_sys,
    input wire logic [5:0] req,
    output logic ext_irq_prog_a_n,
    output logic level_irq_b_n,
    output logic level_irq_a_n,
    output logic edge_irq_n,
    output logic sport_alt_irq_rx_n,
    output logic sport_alt_irq_tx_n
);
    // lines not asked for sit high so they never look active
    always_ff @(posedge clk_sys) begin
        {sport_alt_irq_tx_n, sport_alt_irq_rx_n, edge_irq_n} <= ~req[5:3];
        {level_irq_a_n, level_irq_b_n, ext_irq_prog_a_n} <= ~req[2:0];
    end
endmodule
`default_nettype wire

// ==== test/dsp_interrupt_controller_test.sv ====
`timescale 1ns/100ps
`default_nettype none
module dsp_interrupt_controller_test;
    import irq_ctrl_pkg::*;
    logic clk_sys, rstn, s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic s_axi_arready, s_axi_rvalid, s_axi_awvalid, s_axi_wvalid;
    logic s_axi_bready, s_axi_arvalid, s_axi_rready, vec_valid;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, rd, seed;
    logic [3:0] s_axi_wstrb, sp_word_done, sp_buf_done;
    logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
    logic alt_flag_in, pwd_req, pwrup_wake, byte_dma_port_done, timer_tick;
    logic vec_ack, vec_rti, stk_push, stk_pop, alt_flag_out;
    logic serial_port_one_alt_mode, serial_port_one_sclk_int_en, ext_irq_prog_a_n;
    logic level_irq_b_n, level_irq_a_n, edge_irq_n;
    logic sport_alt_irq_rx_n, sport_alt_irq_tx_n;
    logic [13:0] vec_addr;
    logic [5:0] req;
    int num_errors, total_checks, n, a, b;
    localparam logic [13:0] VT [11] = '{14'h002C, 14'h0004, 14'h0008,
        14'h000C, 14'h0010, 14'h0014, 14'h0018, 14'h001C, 14'h0020,
        14'h0024, 14'h0028};

    irq_ctrl_top u_dut (.*);
    irq_src u_src (.*);

    function automatic logic [31:0] xs;
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    task automatic report_and_stop;
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    // one bus transfer; valids held until their own ready is seen
    task automatic axi(input bit w, input logic [7:0] ad,
                       input logic [31:0] d);
        s_axi_awaddr <= ad;
        s_axi_araddr <= ad;
        s_axi_wdata <= d;
        s_axi_awvalid <= w;
        s_axi_wvalid <= w;
        s_axi_bready <= w;
        s_axi_arvalid <= !w;
        s_axi_rready <= !w;
        n = 0;
        while (!(w ? s_axi_bvalid : s_axi_rvalid) && n < 40) begin
            @(posedge clk_sys);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            n++;
        end
        rd = s_axi_rdata;
        rsp = w ? s_axi_bresp : s_axi_rresp;
        s_axi_bready <= 1'b0;
        s_axi_rready <= 1'b0;
        chk(32'(n < 40), 32'h1);
        if (n >= 40) report_and_stop;
        @(posedge clk_sys);
    endtask

    // wait for a vector, compare, take it, optionally return
    task automatic vec(input logic [13:0] e, input bit rti);
        n = 0;
        while (!vec_valid && n < 40) begin
            @(posedge clk_sys);
            n++;
        end
        chk(32'(vec_addr), 32'(e));
        // a vector that never came fails even if the stale address matches
        if (n >= 40) begin
            num_errors++;
            report_and_stop;
        end
        vec_ack <= 1'b1;
        @(posedge clk_sys);
        vec_ack <= 1'b0;
        vec_rti <= rti;
        @(posedge clk_sys);
        vec_rti <= 1'b0;
        @(posedge clk_sys);
    endtask

    task automatic quiet;
        repeat (3) @(posedge clk_sys);
        repeat (8) begin
            @(posedge clk_sys);
            chk(32'(vec_valid), 32'h0);
        end
    endtask

    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    initial begin
        {rstn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 4'h0;
        {s_axi_arvalid, s_axi_rready, alt_flag_in, pwd_req} = 4'h0;
        {pwrup_wake, byte_dma_port_done, timer_tick, vec_ack} = 4'h0;
        {vec_rti, stk_push, stk_pop} = 3'h0;
        {sp_word_done, sp_buf_done, s_axi_wstrb} = 12'h00F;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
        req = 6'h00;
        seed = 32'd15324;
        repeat (3) @(posedge clk_sys);
        rstn <= 1'b1;
        vec(14'h0000, 1'b0);
        axi(1'b0, ADDR_GIE, 32'h0);
        chk(32'(rd[0]), 32'h1);
        axi(1'b0, 8'hFC, 32'h0);
        chk(32'(rsp), 32'(RESP_SLVERR));
        $display("test reset done");
        axi(1'b1, ADDR_MASK, 32'h3FF);
        for (a = 0; a < 11; a++) begin
            axi(1'b1, ADDR_FORCE, 32'h1 << a);
            vec(VT[a], 1'b1);
        end
        // random pairs: the lower index must win first
        repeat (6) begin
            a = int'(xs() % 11);
            b = int'(xs() % 11);
            axi(1'b1, ADDR_FORCE, (32'h1 << a) | (32'h1 << b));
            vec(VT[a < b ? a : b], 1'b1);
            if (a != b) vec(VT[a < b ? b : a], 1'b1);
        end
        $display("test priority done");
        axi(1'b1, ADDR_MASK, 32'h0);
        axi(1'b1, ADDR_FORCE, 32'h8);
        quiet();
        pwd_req <= 1'b1;
        @(posedge clk_sys);
        pwd_req <= 1'b0;
        vec(14'h002C, 1'b1);
        axi(1'b1, ADDR_MASK, 32'h4);
        chk(32'(vec_valid), 32'h0);
        vec(14'h000C, 1'b1);
        $display("test mask done");
        axi(1'b1, ADDR_MASK, 32'h3FF);
        sp_word_done <= 4'h1;
        {byte_dma_port_done, timer_tick} <= 2'h3;
        @(posedge clk_sys);
        sp_word_done <= 4'h0;
        {byte_dma_port_done, timer_tick} <= 2'h0;
        vec(14'h0010, 1'b1);
        vec(14'h001C, 1'b1);
        vec(14'h0028, 1'b1);
        req <= 6'h08;
        vec(14'h0018, 1'b1);
        quiet();
        req <= 6'h02;
        vec(14'h0008, 1'b1);
        vec(14'h0008, 1'b1);
        req <= 6'h00;
        quiet();
        $display("test pins done");
        // nest on, alt mode, prog_a edge, flag out, port one clock, wake
        axi(1'b1, ADDR_CTRL, 32'h3071);
        chk(32'(serial_port_one_sclk_int_en), 32'h1);
        chk(32'({alt_flag_out, serial_port_one_alt_mode}), 32'h3);
        req <= 6'h01;
        vec(14'h0004, 1'b1);
        quiet();
        axi(1'b0, ADDR_FLAGS, 32'h0);
        chk(32'(rd[4:0]), 32'h07);
        // timer routine left running, then a higher and an equal request
        axi(1'b1, ADDR_FORCE, 32'h400);
        vec(14'h0028, 1'b0);
        axi(1'b1, ADDR_FORCE, 32'h480);
        vec(14'h001C, 1'b1);
        quiet();
        vec_rti <= 1'b1;
        @(posedge clk_sys);
        vec_rti <= 1'b0;
        vec(14'h0028, 1'b1);
        $display("test nest done");
        // global disable holds a request back; a forced clear drops it
        axi(1'b1, ADDR_GIE, 32'h2);
        axi(1'b0, ADDR_GIE, 32'h0);
        chk(32'(rd[0]), 32'h0);
        axi(1'b1, ADDR_FORCE, 32'h400);
        quiet();
        axi(1'b1, ADDR_FORCE, 32'h0400_0000);
        axi(1'b1, ADDR_GIE, 32'h1);
        quiet();
        pwrup_wake <= 1'b1;
        @(posedge clk_sys);
        pwrup_wake <= 1'b0;
        vec(14'h0000, 1'b0);
        $display("test enable done");
        report_and_stop;
    end
endmodule
`default_nettype wire
